// [usr_pkg.sv]
package usr_pkg;
  // Register offsets, as printed (byte addresses on the plain register port).
  localparam logic [7:0] ADDR_FLAG = 8'h0c;
  localparam logic [7:0] ADDR_RXCTL = 8'h18;
  localparam logic [7:0] ADDR_TXDATA = 8'h19;
  localparam logic [7:0] ADDR_RXDATA = 8'h1a;
  localparam logic [7:0] ADDR_ENABLE = 8'h8c;
  localparam logic [7:0] ADDR_TXCTL = 8'h98;
  localparam logic [7:0] ADDR_BAUD = 8'h99;
  // Receive control field positions.
  localparam int RX_PORT_EN = 7;
  localparam int RX_NINE = 6;
  localparam int RX_SINGLE = 5;
  localparam int RX_CONT = 4;
  localparam int RX_FRAMING = 2;
  localparam int RX_OVERRUN = 1;
  localparam int RX_NINTH = 0;
  // Transmit control field positions.
  localparam int TX_CLK_SRC = 7;
  localparam int TX_NINE = 6;
  localparam int TX_EN = 5;
  localparam int TX_SYNC = 4;
  localparam int TX_HIGH_SPEED = 2;
  localparam int TX_SH_EMPTY = 1;
  localparam int TX_NINTH = 0;
  // Flag and enable field positions.
  localparam int FLAG_RX = 5;
  localparam int FLAG_TX = 4;
  // Reset values.
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_TXCTL = 8'h02;
  // Baud phase counter width and bits per received word, eight or nine.
  localparam int BAUD_W = 8;
  localparam logic [3:0] BITS_EIGHT = 4'h8;
  localparam logic [3:0] BITS_NINE = 4'h9;
  // Receive controller states.
  typedef enum logic [1:0] {
    USR_IDLE = 2'b00,
    USR_SHIFT = 2'b01,
    USR_DONE = 2'b10
  } usr_state_e;
endpackage : usr_pkg

// [usr_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
// Two-entry receive store: nine bits per entry, data plus ninth bit.
module usr_fifo
  import usr_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Write side.
  input wire logic push,
  input wire logic [8:0] push_word,
  // Read side.
  input wire logic pop,
  input wire logic flush,
  output logic [8:0] head_word,
  output logic full,
  output logic empty
);
  // Storage entries addressed by index.
  logic [8:0] mem [2];
  // Read and write pointers and fill count.
  logic rd_ptr;
  logic wr_ptr;
  logic [1:0] count;
  // Accepted operations.
  wire do_push = push && !full;
  wire do_pop = pop && !empty;

  assign full = (count == 2'h2);
  assign empty = (count == 2'h0);
  assign head_word = mem[rd_ptr];

  // Pointer and count update; a flush empties the store.
  always_ff @(posedge clock) begin
    if (rst || flush) begin
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
      count <= 2'h0;
    end else begin
      if (do_push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (do_pop) begin
        rd_ptr <= ~rd_ptr;
      end
      count <= count + {1'b0, do_push} - {1'b0, do_pop};
    end
  end

  // Entry write.
  always_ff @(posedge clock) begin
    if (do_push) begin
      mem[wr_ptr] <= push_word;
    end
  end

  // The fill count never passes two.
  a_fifo_bound: assert property (@(posedge clock) disable iff (rst) count <= 2'h2)
    else $error("receive store count above two");
endmodule : usr_fifo
`default_nettype wire

// [usr_top.sv]
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module usr_top
  import usr_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Register port.
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  // Serial clock pin, three signals.
  input wire logic serial_clk_in,
  output logic serial_clk_out,
  output logic serial_clk_oe,
  // Serial data pin, three signals.
  input wire logic serial_data_pin_in,
  output logic serial_data_pin_out,
  output logic serial_data_pin_oe,
  // Receive interrupt request.
  output logic rx_irq
);
  // Software visible registers.
  logic [7:0] baud_divisor;
  logic [7:0] peripheral_enable_reg;
  logic [7:0] transmit_data_reg;
  logic port_enable;
  logic nine_bit_rx_enable;
  logic single_receive_enable;
  logic continuous_receive_enable;
  logic overrun_error;
  logic rx_ninth_bit;
  logic master_clock_source;
  logic nine_bit_tx_enable;
  logic transmit_enable;
  logic sync_mode;
  logic high_speed_baud;
  logic tx_ninth_bit;
  logic transmit_flag;
  logic [7:0] rx_visible;
  // Transmit shifter: start, eight data bits, ninth, stop.
  logic [10:0] tx_shift;
  logic [3:0] tx_left;
  logic shifter_empty;
  // Pin synchronisers; logic reads only the second data stage and never reads the clock one.
  logic [1:0] data_sync;
  logic [1:0] clk_sync;
  // Baud timing and receive engine state.
  logic [BAUD_W-1:0] baud_cnt;
  usr_state_e state;
  usr_state_e next_state;
  logic [8:0] receive_shifter;
  logic [3:0] bit_cnt;
  // Read data and FIFO side signals.
  logic [7:0] next_rdata;
  logic [8:0] fifo_head;
  logic fifo_full;
  logic fifo_empty;

  // Decodes shared by read and write paths.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction : hit

  wire wr_rxctl = wr_en && hit(addr, ADDR_RXCTL);
  wire wr_txctl = wr_en && hit(addr, ADDR_TXCTL);
  wire rd_rxdata = rd_en && hit(addr, ADDR_RXDATA);
  wire baud_tick = (baud_cnt == RST_ZERO);
  wire rx_req = single_receive_enable || continuous_receive_enable;
  wire sync_master = port_enable && sync_mode && master_clock_source;
  wire rx_active = (state == USR_SHIFT);
  wire [3:0] bits_needed = nine_bit_rx_enable ? BITS_NINE : BITS_EIGHT;
  // Falling edge of the driven serial clock: data sample point.
  wire fall_tick = rx_active && baud_tick && serial_clk_out;
  wire last_bit = fall_tick && (bit_cnt == bits_needed - 4'h1);
  // Word assembled from the shifter including the bit just sampled.
  wire [8:0] new_word = nine_bit_rx_enable ? {data_sync[1], receive_shifter[8:1]}
                                           : {1'b0, data_sync[1], receive_shifter[8:2]};
  wire can_push = last_bit && !overrun_error && !fifo_full;
  wire set_overrun = last_bit && fifo_full && !overrun_error;
  wire receive_flag = !fifo_empty;
  wire tx_start = wr_en && hit(addr, ADDR_TXDATA) && transmit_enable;

  // Two-entry receive store holding data and ninth bit.
  usr_fifo u_fifo (
    .clock(clock),
    .rst(rst),
    .push(can_push),
    .push_word({new_word[8], new_word[7:0]}),
    .pop(rd_rxdata),
    .flush(1'b0),
    .head_word(fifo_head),
    .full(fifo_full),
    .empty(fifo_empty)
  );

  // Two-stage synchronisers for both pins.
  always_ff @(posedge clock) begin
    if (rst) begin
      data_sync <= 2'h0;
      clk_sync <= 2'h0;
    end else begin
      data_sync <= {data_sync[0], serial_data_pin_in};
      clk_sync <= {clk_sync[0], serial_clk_in};
    end
  end

  // Receive control and software writes to receive control.
  always_ff @(posedge clock) begin
    if (rst) begin
      {port_enable, nine_bit_rx_enable} <= 2'h0;
      {single_receive_enable, continuous_receive_enable} <= 2'h0;
      overrun_error <= 1'b0;
    end else begin
      if (wr_rxctl) begin
        port_enable <= wdata[RX_PORT_EN];
        nine_bit_rx_enable <= wdata[RX_NINE];
        continuous_receive_enable <= wdata[RX_CONT];
      end
      // Single reception ends itself after one word unless continuous wins.
      if (wr_rxctl) begin
        single_receive_enable <= wdata[RX_SINGLE];
      end else if (last_bit && !continuous_receive_enable) begin
        single_receive_enable <= 1'b0;
      end
      // A new overrun wins over a clear in the same cycle.
      if (set_overrun) begin
        overrun_error <= 1'b1;
      end else if (wr_rxctl && !wdata[RX_CONT]) begin
        overrun_error <= 1'b0;
      end
    end
  end

  // Visible data and ninth bit load from the FIFO head on each read while it holds a word.
  always_ff @(posedge clock) begin
    if (rst) begin
      rx_visible <= RST_ZERO;
      rx_ninth_bit <= 1'b0;
    end else if (rd_rxdata && !fifo_empty) begin
      rx_visible <= fifo_head[7:0];
      rx_ninth_bit <= fifo_head[8];
    end
  end

  // Plain software registers: divisor, enables, transmit control.
  always_ff @(posedge clock) begin
    if (rst) begin
      baud_divisor <= RST_ZERO;
      peripheral_enable_reg <= RST_ZERO;
      {master_clock_source, nine_bit_tx_enable, transmit_enable} <= 3'h0;
      {sync_mode, high_speed_baud, tx_ninth_bit} <= 3'h0;
    end else begin
      if (wr_en && hit(addr, ADDR_BAUD)) begin
        baud_divisor <= wdata;
      end
      if (wr_en && hit(addr, ADDR_ENABLE)) begin
        peripheral_enable_reg <= wdata;
      end
      if (wr_txctl) begin
        master_clock_source <= wdata[TX_CLK_SRC];
        nine_bit_tx_enable <= wdata[TX_NINE];
        transmit_enable <= wdata[TX_EN];
        sync_mode <= wdata[TX_SYNC];
        high_speed_baud <= wdata[TX_HIGH_SPEED];
        tx_ninth_bit <= wdata[TX_NINTH];
      end
    end
  end

  // Baud counter: reloads from the divisor, one tick per half receive bit and per whole transmit bit.
  always_ff @(posedge clock) begin
    if (rst || !port_enable) begin
      baud_cnt <= RST_ZERO;
    end else if (baud_tick) begin
      baud_cnt <= baud_divisor;
    end else begin
      baud_cnt <= baud_cnt - 8'h01;
    end
  end

  // Receive state selection.
  always_comb begin
    next_state = state;
    unique case (state)
      USR_IDLE: begin
        if (sync_master && rx_req && !overrun_error) begin
          next_state = USR_SHIFT;
        end
      end
      USR_SHIFT: begin
        if (!sync_master || !rx_req) begin
          next_state = USR_IDLE;
        end else if (last_bit) begin
          next_state = USR_DONE;
        end
      end
      USR_DONE: begin
        next_state = USR_IDLE;
      end
      default: begin
        next_state = USR_IDLE;
      end
    endcase
  end

  // Receive engine: serial clock generation and bit shifting.
  always_ff @(posedge clock) begin
    if (rst) begin
      state <= USR_IDLE;
      serial_clk_out <= 1'b0;
      serial_clk_oe <= 1'b0;
      receive_shifter <= 9'h000;
      bit_cnt <= 4'h0;
    end else begin
      state <= next_state;
      serial_clk_oe <= sync_master;
      if (!rx_active) begin
        serial_clk_out <= 1'b0;
        bit_cnt <= 4'h0;
      end else if (baud_tick) begin
        serial_clk_out <= ~serial_clk_out;
        if (serial_clk_out) begin
          receive_shifter <= {data_sync[1], receive_shifter[8:1]};
          bit_cnt <= last_bit ? 4'h0 : bit_cnt + 4'h1;
        end
      end
    end
  end

  // Transmit flag, shifter and data pin for asynchronous transmission.
  always_ff @(posedge clock) begin
    if (rst) begin
      transmit_data_reg <= RST_ZERO;
      transmit_flag <= 1'b0;
      tx_shift <= 11'h7ff;
      tx_left <= 4'h0;
      shifter_empty <= 1'b1;
      serial_data_pin_out <= 1'b1;
      serial_data_pin_oe <= 1'b0;
    end else begin
      serial_data_pin_oe <= port_enable && !sync_mode;
      if (tx_start) begin
        transmit_data_reg <= wdata;
        transmit_flag <= 1'b0;
        tx_shift <= {1'b1, nine_bit_tx_enable ? tx_ninth_bit : 1'b1, wdata, 1'b0};
        tx_left <= nine_bit_tx_enable ? 4'hb : 4'ha;
        shifter_empty <= 1'b0;
      end else begin
        if (tx_left != 4'h0 && baud_tick) begin
          serial_data_pin_out <= tx_shift[0];
          tx_shift <= {1'b1, tx_shift[10:1]};
          tx_left <= tx_left - 4'h1;
        end else if (tx_left == 4'h0 && !shifter_empty) begin
          shifter_empty <= 1'b1;
          transmit_flag <= transmit_enable;
        end
        // Setting the enable wins over a frame that ends in the same cycle.
        if (wr_txctl && wdata[TX_EN]) begin
          transmit_flag <= 1'b1;
        end
      end
    end
  end

  // Read data: selection is combinational, registered for next cycle.
  always_comb begin
    next_rdata = RST_ZERO;
    unique case (addr)
      ADDR_FLAG: next_rdata = {2'h0, receive_flag, transmit_flag, 4'h0};
      ADDR_RXCTL: next_rdata = {port_enable, nine_bit_rx_enable, single_receive_enable,
                                continuous_receive_enable, 2'h0, overrun_error, rx_ninth_bit};
      ADDR_RXDATA: next_rdata = fifo_empty ? rx_visible : fifo_head[7:0];
      ADDR_ENABLE: next_rdata = peripheral_enable_reg;
      ADDR_TXCTL: next_rdata = {master_clock_source, nine_bit_tx_enable, transmit_enable,
                                sync_mode, 1'b0, high_speed_baud, shifter_empty, tx_ninth_bit};
      ADDR_BAUD: next_rdata = baud_divisor;
      default: next_rdata = RST_ZERO;
    endcase
  end

  // Read data register and interrupt output.
  always_ff @(posedge clock) begin
    if (rst) begin
      rdata <= RST_ZERO;
      rx_irq <= 1'b0;
    end else begin
      rdata <= rd_en ? next_rdata : RST_ZERO;
      rx_irq <= receive_flag && peripheral_enable_reg[FLAG_RX];
    end
  end

  // Checks on the receive and transmit paths.
  a_irq_gated: assert property (@(posedge clock) disable iff (rst)
    rx_irq |-> $past(peripheral_enable_reg[FLAG_RX])) else $error("irq while disabled");
  a_overrun_blocks: assert property (@(posedge clock) disable iff (rst)
    overrun_error && fifo_empty |=> fifo_empty) else $error("push during overrun");
  a_overrun_sets: assert property (@(posedge clock) disable iff (rst)
    set_overrun |=> overrun_error) else $error("overrun not set");
  a_overrun_holds: assert property (@(posedge clock) disable iff (rst)
    overrun_error && !(wr_rxctl && !wdata[RX_CONT]) |=> overrun_error)
    else $error("overrun cleared early");
  a_single_stops: assert property (@(posedge clock) disable iff (rst)
    last_bit && !continuous_receive_enable && !wr_rxctl |=> !single_receive_enable)
    else $error("single receive kept running");
  a_flag_follows: assert property (@(posedge clock) disable iff (rst)
    can_push |=> receive_flag) else $error("flag not set after transfer");
  a_tx_flag_set: assert property (@(posedge clock) disable iff (rst)
    wr_txctl && wdata[TX_EN] && !tx_start |=> transmit_flag) else $error("tx flag missing");
  a_tx_starts: assert property (@(posedge clock) disable iff (rst)
    tx_start |=> !shifter_empty) else $error("transmit did not start");
  c_word_in: cover property (@(posedge clock) can_push);
  c_overrun: cover property (@(posedge clock) set_overrun);
  c_tx: cover property (@(posedge clock) tx_start);
endmodule : usr_top
`default_nettype wire

// [usr_remote.sv]
`timescale 1ns/1ps
`default_nettype none
// Remote serial device that answers the master clock with queued bits.
module usr_remote (
  // Serial clock made by the master.
  input wire logic sclk,
  // Data line toward the master.
  output logic data
);
  // Bits still to send, first bit at the front.
  bit q[$];
  initial data = 1'b0;
  // Queue one word, least significant bit first.
  task automatic push(input logic [8:0] w, input int n);
    for (int i = 0; i < n; i++) q.push_back(w[i]);
  endtask : push
  // Forget whatever was not sent yet.
  task automatic drop();
    q.delete();
  endtask : drop
  // A bit goes out on the rise so it is steady at the sampling fall.
  always @(posedge sclk) begin
    if (q.size() > 0) data <= q.pop_front();
    else data <= ~data; // With nothing queued the line keeps changing.
  end
endmodule : usr_remote
`default_nettype wire

// [tb_usr_top.sv]
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the serial receive and transmit start logic.
module tb_usr_top;
  import usr_pkg::*;
  logic clock, rst, wr_en, rd_en, lclk; // Clocks, reset and strobes.
  logic [7:0] addr, wdata, rdata, v; // Register port and read result.
  logic c_out, c_oe, d_out, d_oe, rm_data, rx_irq; // Pin signals.
  logic [8:0] w; // Word under test.
  int seed = 73;
  int n_errors = 0;
  int compares = 0;
  int q[$]; // Model of the two-entry receive store.
  int ov; // Model of the overrun state.
  // Resolve the two shared pins from the design's output enables.
  wire logic cpin = c_oe ? c_out : lclk;
  wire logic dpin = d_oe ? d_out : rm_data;
  usr_top i_usr_top (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .serial_clk_in(cpin), .serial_clk_out(c_out),
    .serial_clk_oe(c_oe), .serial_data_pin_in(dpin), .serial_data_pin_out(d_out),
    .serial_data_pin_oe(d_oe), .rx_irq(rx_irq));
  usr_remote i_usr_remote (.sclk(c_out), .data(rm_data));
  // Core clock and an unrelated link clock.
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    lclk = 1'b0;
    forever #62.5 lclk = ~lclk;
  end
  // Compare one value and count it.
  task automatic chk(input string nm, input logic [8:0] got, input logic [8:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // One write cycle, then an idle cycle so strobes never merge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
    @(posedge clock);
  endtask : wr
  // One read cycle; the data stand only in the following cycle.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1 d = rdata;
    @(posedge clock);
  endtask : rd
  // Poll a register bit until it is set, with a bounded count.
  task automatic wait_bit(input logic [7:0] a, input int b);
    for (int i = 0; i < 400; i++) begin
      rd(a, v);
      if (v[b] === 1'b1) return;
    end
    chk("wait_bit", v[b], 1'b1);
  endtask : wait_bit
  // Print the counts and the verdict, then stop.
  task automatic finish_test();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test
  // Cut a hang short.
  initial begin
    #200us;
    n_errors++;
    finish_test();
  end
  // Main sequence.
  initial begin
    static logic [7:0] ta[6] = '{ADDR_FLAG, ADDR_RXDATA, ADDR_ENABLE, ADDR_TXCTL, ADDR_BAUD,
      8'h55};
    static logic [7:0] te[6] = '{8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00};
    rst = 1'b1;
    addr = 8'h00;
    wdata = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    // Reset values, an unmapped place and the read-only flag.
    for (int i = 0; i < 6; i++) begin
      rd(ta[i], v);
      chk("reset_value", v, te[i]);
    end
    wr(ADDR_FLAG, 8'hff);
    rd(ADDR_FLAG, v);
    chk("flag_read_only", v[FLAG_RX], 1'b0);
    $display("test reset done");
    // Single word reception with the interrupt enabled.
    wr(ADDR_BAUD, 8'h03);
    wr(ADDR_TXCTL, 8'h90);
    wr(ADDR_ENABLE, 8'h20);
    w = 9'($random(seed));
    i_usr_remote.push(w, 8);
    wr(ADDR_RXCTL, 8'ha0);
    wait_bit(ADDR_FLAG, FLAG_RX);
    #1 chk("irq_on", rx_irq, 1'b1);
    chk("clk_drive", c_oe, 1'b1);
    rd(ADDR_RXCTL, v);
    chk("single_cleared", v[RX_SINGLE], 1'b0);
    rd(ADDR_RXDATA, v);
    chk("rx_word", v, w[7:0]);
    rd(ADDR_FLAG, v);
    chk("flag_clear", v[FLAG_RX], 1'b0);
    #1 chk("irq_off", rx_irq, 1'b0);
    repeat (150) @(posedge clock);
    rd(ADDR_FLAG, v);
    chk("no_second_word", v[FLAG_RX], 1'b0);
    $display("test single done");
    // Both enables: three words overrun the store.
    q.delete();
    ov = 0;
    for (int i = 0; i < 3; i++) begin
      w = 9'($random(seed));
      i_usr_remote.push(w, 8);
      if (ov == 0 && q.size() < 2) q.push_back(w[7:0]);
      else ov = 1;
    end
    wr(ADDR_RXCTL, 8'hb0);
    wait_bit(ADDR_RXCTL, RX_OVERRUN);
    for (int i = 0; i < 2; i++) begin
      rd(ADDR_RXDATA, v);
      chk("fifo_word", v, 9'(q.pop_front()));
    end
    repeat (150) @(posedge clock);
    rd(ADDR_FLAG, v);
    chk("blocked_flag", v[FLAG_RX], 1'b0);
    rd(ADDR_RXCTL, v);
    chk("overrun_held", v[RX_OVERRUN], 9'(ov));
    wr(ADDR_RXCTL, 8'h80);
    i_usr_remote.drop();
    rd(ADDR_RXCTL, v);
    chk("overrun_cleared", v[RX_OVERRUN], 1'b0);
    $display("test overrun done");
    // Nine-bit word with the interrupt masked.
    wr(ADDR_ENABLE, 8'h00);
    w = 9'($random(seed));
    w[8] = 1'b1;
    i_usr_remote.push(w, 9);
    wr(ADDR_RXCTL, 8'he0);
    wait_bit(ADDR_FLAG, FLAG_RX);
    #1 chk("irq_masked", rx_irq, 1'b0);
    rd(ADDR_RXCTL, v);
    chk("old_ninth_bit", v[RX_NINTH], 1'b0);
    rd(ADDR_RXDATA, v);
    chk("rx_nine_word", v, w[7:0]);
    rd(ADDR_RXCTL, v);
    chk("ninth_bit", v[RX_NINTH], 1'b1);
    $display("test nine bit done");
    // Asynchronous nine-bit transmission.
    wr(ADDR_RXCTL, 8'h80);
    wr(ADDR_TXCTL, 8'h60);
    rd(ADDR_FLAG, v);
    chk("tx_flag", v[FLAG_TX], 1'b1);
    w = 9'($random(seed));
    wr(ADDR_TXDATA, w[7:0]);
    for (int i = 0; i < 60 && d_out !== 1'b0; i++) @(posedge clock) #1;
    chk("tx_drive", d_oe, 1'b1);
    repeat (2) @(posedge clock);
    #1 chk("tx_start", d_out, 1'b0);
    for (int i = 0; i < 10; i++) begin
      repeat (4) @(posedge clock);
      #1 chk("tx_bit", d_out, (i < 8) ? w[i] : ((i == 8) ? 1'b0 : 1'b1));
    end
    $display("test transmit done");
    finish_test();
  end
endmodule : tb_usr_top
`default_nettype wire
